/* src/rgi_pkg.sv */
package rgi_pkg;

	// ----------------------------------------------------------------
	// transaction states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RGI_ST_IDLE,
		RGI_ST_ADDR,
		RGI_ST_PTR,
		RGI_ST_WDATA,
		RGI_ST_RDATA,
		RGI_ST_SKIP
	} rgi_state_t;

	// ----------------------------------------------------------------
	// bus address and register pointers
	// ----------------------------------------------------------------
	localparam logic [5:0] RGI_ADDR_BASE = 6'h23;
	localparam logic [7:0] RGI_REG_MARGIN = 8'h00;
	localparam logic [7:0] RGI_REG_DOF = 8'h01;
	localparam logic [7:0] RGI_REG_RST = 8'h00;
	localparam logic RGI_DIR_READ = 1'b1;

	// ----------------------------------------------------------------
	// bit counter marks within one nine-pulse byte
	// ----------------------------------------------------------------
	localparam logic [3:0] RGI_BIT_ACK = 4'h8;
	localparam logic [3:0] RGI_BIT_END = 4'h9;

	// ----------------------------------------------------------------
	// fields of the margin and deadtime/ovp/frequency registers
	// ----------------------------------------------------------------
	localparam int RGI_OFS_MSB = 5;
	localparam int RGI_FREQ_MSB = 2;
	localparam int RGI_OVP_BIT = 3;
	localparam int RGI_DT_BIT = 4;
	localparam int RGI_PH_BIT = 7;

	// ----------------------------------------------------------------
	// pin positions in the synchroniser vector
	// ----------------------------------------------------------------
	localparam int RGI_PIN_N = 6;
	localparam int RGI_PIN_SDA = 0;
	localparam int RGI_PIN_SCL = 1;
	localparam int RGI_PIN_PH2 = 2;
	localparam int RGI_PIN_RST = 3;
	localparam int RGI_PIN_HI = 4;
	localparam int RGI_PIN_POR = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int RGI_CLK_HZ = 50_000_000;
	localparam int RGI_FAST_BPS = 400_000;
	localparam int RGI_FAST_BIT_CYC = RGI_CLK_HZ / RGI_FAST_BPS;
	localparam int RGI_SYNC_LAT = 4;

endpackage

/* src/rgi_slave.sv */
// Behaviour
// - bus works only while supply above threshold
// - slave only, never drives the clock line
// - data changes only while clock is low
// - start and stop seen while clock high
// - eight bits msb first, then acknowledge
// - nine pulses per byte, address first
// - strap picks address 1000_110 or 1000_111
// - strap sampled at power-up, then held
// - direction bit 0 write, 1 read
// - acknowledge own address, else release line
// - pointer 0 margin, 1 deadtime/ovp/frequency
// - acknowledge a valid pointer byte
// - write is control, pointer, data, stop
// - written values applied at stop
// - second data byte lands in second register after pointer 0, dropped after pointer 1
// - only write and current-pointer read
// - phase setting used only with pin low
// - offset 0 to 787.5mV in 12.5mV steps
// - frequency plus or minus 15 or 30 percent
// - works up to 400 kbps
// - data line only pulled low or released
// - read after pointer write returns that register
// - master ack after first byte sends second, from pointer 0 only
// - registers zero at power-up and supply loss
// - strap pulled low clears both registers
module rgi_slave (
	input wire logic ref_clk_i, // system clock
	input wire logic arst_n_i, // async reset
	input wire logic por_ok_i, // supply above por
	input wire logic softstart_address_strap_pin_hi_i, // strap to supply
	input wire logic softstart_address_strap_pin_rst_i, // strap below 0.4 V
	input wire logic second_phase_enable_pin_i, // phase pin level
	input wire logic scl_i, // clock line level
	output logic scl_o, // clock line drive value
	output logic scl_oe_n_o, // clock line enable, low drives
	input wire logic sda_i, // data line level
	output logic sda_o, // data line drive value
	output logic sda_oe_n_o, // data line enable, low drives
	output logic [7:0] margin_offset_register_o, // applied margin reg
	output logic [7:0] deadtime_ovp_frequency_register_o, // applied reg
	output logic [5:0] offset_steps_o, // offset in 12.5 mV steps
	output logic [2:0] freq_adjust_o, // frequency selection
	output logic ovp_alternate_o, // alternate ovp level
	output logic deadtime_scheme_o, // deadtime scheme select
	output logic two_phase_o, // both phases firing
	output logic bus_active_o // serial interface live
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [rgi_pkg::RGI_PIN_N-1:0] s0;
		logic [rgi_pkg::RGI_PIN_N-1:0] s1;
		logic [rgi_pkg::RGI_PIN_N-1:0] s2;
		logic [rgi_pkg::RGI_PIN_N-1:0] f;
		logic [rgi_pkg::RGI_PIN_N-1:0] p;
		rgi_pkg::rgi_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic [6:0] addr;
		logic [7:0] pointer;
		logic [1:0] wslot;
		logic rslot;
		logic rw;
		logic m_ack;
		logic drive;
		logic [7:0] stg1;
		logic [7:0] stg2;
		logic stg1_v;
		logic stg2_v;
		logic [7:0] reg1;
		logic [7:0] reg2;
	} rgi_regs_t;

	rgi_regs_t q;
	rgi_regs_t d;
	logic [rgi_pkg::RGI_PIN_N-1:0] pins;
	logic scl_f;
	logic sda_f;
	logic por_f;
	logic clr_f;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic ptr_ok;

	assign pins[rgi_pkg::RGI_PIN_SDA] = sda_i;
	assign pins[rgi_pkg::RGI_PIN_SCL] = scl_i;
	assign pins[rgi_pkg::RGI_PIN_PH2] = second_phase_enable_pin_i;
	assign pins[rgi_pkg::RGI_PIN_RST] = softstart_address_strap_pin_rst_i;
	assign pins[rgi_pkg::RGI_PIN_HI] = softstart_address_strap_pin_hi_i;
	assign pins[rgi_pkg::RGI_PIN_POR] = por_ok_i;

	assign scl_f = q.f[rgi_pkg::RGI_PIN_SCL];
	assign sda_f = q.f[rgi_pkg::RGI_PIN_SDA];
	assign por_f = q.f[rgi_pkg::RGI_PIN_POR];
	assign clr_f = q.f[rgi_pkg::RGI_PIN_RST];

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	assign scl_rise = scl_f & ~q.p[rgi_pkg::RGI_PIN_SCL];
	assign scl_fall = ~scl_f & q.p[rgi_pkg::RGI_PIN_SCL];
	// both lines share one filter delay, so their order is kept
	assign start_det = scl_f & q.p[rgi_pkg::RGI_PIN_SCL] & ~sda_f &
		q.p[rgi_pkg::RGI_PIN_SDA];
	assign stop_det = scl_f & q.p[rgi_pkg::RGI_PIN_SCL] & sda_f &
		~q.p[rgi_pkg::RGI_PIN_SDA];
	assign ptr_ok = (q.shreg == rgi_pkg::RGI_REG_MARGIN) ||
		(q.shreg == rgi_pkg::RGI_REG_DOF);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		// three-stage sync, a level counts once stages two and three agree
		d.s0 = pins;
		d.s1 = q.s0;
		d.s2 = q.s1;
		d.f = (q.s1 & q.s2) | (q.f & (q.s1 ^ q.s2));
		d.p = q.f;

		if (!por_f) begin
			// supply low: interface dead, registers and address cleared
			d.state = rgi_pkg::RGI_ST_IDLE;
			d.drive = 1'b0;
			d.bitcnt = 4'h0;
			d.addr = 7'h00;
			d.pointer = rgi_pkg::RGI_REG_MARGIN;
			d.stg1_v = 1'b0;
			d.stg2_v = 1'b0;
			d.reg1 = rgi_pkg::RGI_REG_RST;
			d.reg2 = rgi_pkg::RGI_REG_RST;
		end else begin
			if (!q.p[rgi_pkg::RGI_PIN_POR]) begin
				d.addr = {rgi_pkg::RGI_ADDR_BASE,
					q.f[rgi_pkg::RGI_PIN_HI]};
			end
			if (start_det) begin
				// a start mid-transfer also restarts, dropping staged bytes
				d.state = rgi_pkg::RGI_ST_ADDR;
				d.bitcnt = 4'h0;
				d.drive = 1'b0;
				d.stg1_v = 1'b0;
				d.stg2_v = 1'b0;
			end else if (stop_det) begin
				d.state = rgi_pkg::RGI_ST_IDLE;
				d.drive = 1'b0;
				d.stg1_v = 1'b0;
				d.stg2_v = 1'b0;
				if (q.stg1_v) begin
					d.reg1 = q.stg1;
				end
				if (q.stg2_v) begin
					d.reg2 = q.stg2;
				end
			end else if (scl_rise && q.state != rgi_pkg::RGI_ST_IDLE) begin
				if (q.bitcnt < rgi_pkg::RGI_BIT_ACK) begin
					d.shreg = {q.shreg[6:0], sda_f};
				end else begin
					d.m_ack = ~sda_f;
				end
				if (q.bitcnt < rgi_pkg::RGI_BIT_END) begin
					d.bitcnt = q.bitcnt + 4'h1;
				end
			end else if (scl_fall) begin
				// every drive change lands while the clock is low
				unique case (q.state)
					rgi_pkg::RGI_ST_IDLE, rgi_pkg::RGI_ST_SKIP: begin
						d.drive = 1'b0;
					end
					rgi_pkg::RGI_ST_ADDR: begin
						if (q.bitcnt == rgi_pkg::RGI_BIT_ACK) begin
							if (q.shreg[7:1] == q.addr) begin
								d.drive = 1'b1;
								d.rw = q.shreg[0];
							end else begin
								d.state = rgi_pkg::RGI_ST_SKIP;
							end
						end else if (q.bitcnt == rgi_pkg::RGI_BIT_END) begin
							d.bitcnt = 4'h0;
							if (q.rw == rgi_pkg::RGI_DIR_READ) begin
								d.state = rgi_pkg::RGI_ST_RDATA;
								d.rslot = q.pointer[0];
								d.tx = q.pointer[0] ? q.reg2 : q.reg1;
								d.drive = q.pointer[0] ? ~q.reg2[7] :
									~q.reg1[7];
							end else begin
								d.state = rgi_pkg::RGI_ST_PTR;
								d.drive = 1'b0;
							end
						end
					end
					rgi_pkg::RGI_ST_PTR: begin
						if (q.bitcnt == rgi_pkg::RGI_BIT_ACK) begin
							if (ptr_ok) begin
								d.drive = 1'b1;
								d.pointer = q.shreg;
							end else begin
								d.state = rgi_pkg::RGI_ST_SKIP;
							end
						end else if (q.bitcnt == rgi_pkg::RGI_BIT_END) begin
							d.bitcnt = 4'h0;
							d.drive = 1'b0;
							d.state = rgi_pkg::RGI_ST_WDATA;
							d.wslot = {1'b0, q.pointer[0]};
						end
					end
					rgi_pkg::RGI_ST_WDATA: begin
						if (q.bitcnt == rgi_pkg::RGI_BIT_ACK) begin
							d.drive = 1'b1;
							if (q.wslot == 2'h0) begin
								d.stg1 = q.shreg;
								d.stg1_v = 1'b1;
							end else if (q.wslot == 2'h1) begin
								d.stg2 = q.shreg;
								d.stg2_v = 1'b1;
							end
							if (q.wslot != 2'h2) begin
								d.wslot = q.wslot + 2'h1;
							end
						end else if (q.bitcnt == rgi_pkg::RGI_BIT_END) begin
							d.bitcnt = 4'h0;
							d.drive = 1'b0;
						end
					end
					rgi_pkg::RGI_ST_RDATA: begin
						if (q.bitcnt == rgi_pkg::RGI_BIT_ACK) begin
							d.drive = 1'b0;
						end else if (q.bitcnt == rgi_pkg::RGI_BIT_END) begin
							d.bitcnt = 4'h0;
							if (q.m_ack && !q.rslot) begin
								d.rslot = 1'b1;
								d.tx = q.reg2;
								d.drive = ~q.reg2[7];
							end else begin
								d.state = rgi_pkg::RGI_ST_SKIP;
								d.drive = 1'b0;
							end
						end else if (q.bitcnt != 4'h0) begin
							d.tx = {q.tx[6:0], 1'b1};
							d.drive = ~q.tx[6];
						end
					end
				endcase
			end
			// strap pulled low wins over any write in flight
			if (clr_f) begin
				d.reg1 = rgi_pkg::RGI_REG_RST;
				d.reg2 = rgi_pkg::RGI_REG_RST;
				d.stg1_v = 1'b0;
				d.stg2_v = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign scl_o = 1'b1;
	assign scl_oe_n_o = 1'b1;
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~q.drive;
	assign margin_offset_register_o = q.reg1;
	assign deadtime_ovp_frequency_register_o = q.reg2;
	assign offset_steps_o = q.reg1[rgi_pkg::RGI_OFS_MSB:0];
	assign freq_adjust_o = q.reg2[rgi_pkg::RGI_FREQ_MSB:0];
	assign ovp_alternate_o = q.reg2[rgi_pkg::RGI_OVP_BIT];
	assign deadtime_scheme_o = q.reg2[rgi_pkg::RGI_DT_BIT];
	// pin high forces both phases; the register bit only counts when low
	assign two_phase_o = q.f[rgi_pkg::RGI_PIN_PH2] |
		~q.reg2[rgi_pkg::RGI_PH_BIT];
	assign bus_active_o = por_f;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DEAD_WITHOUT_POR: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) !por_f |=> !q.drive && q.state ==
		rgi_pkg::RGI_ST_IDLE)
		else $error("interface active without supply");

	AST_START_TO_ADDR: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && start_det |=>
		q.state == rgi_pkg::RGI_ST_ADDR && q.bitcnt == 4'h0)
		else $error("start not taken");

	AST_STOP_TO_IDLE: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && stop_det |=>
		q.state == rgi_pkg::RGI_ST_IDLE && !q.drive)
		else $error("stop not taken");

	AST_ADDR_ACK: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && scl_fall && !clr_f &&
		q.state == rgi_pkg::RGI_ST_ADDR && q.bitcnt == 4'h8 &&
		q.shreg[7:1] == q.addr |=> !sda_oe_n_o ##1 !sda_oe_n_o)
		else $error("own address not acknowledged");

	AST_ADDR_NACK: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) scl_fall && q.state ==
		rgi_pkg::RGI_ST_ADDR && q.bitcnt == 4'h8 &&
		q.shreg[7:1] != q.addr |=> sda_oe_n_o &&
		q.state != rgi_pkg::RGI_ST_ADDR)
		else $error("foreign address acknowledged");

	AST_ADDR_LATCH: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) $rose(por_f) |=> q.addr ==
		{6'h23, $past(q.f[rgi_pkg::RGI_PIN_HI])})
		else $error("address not sampled at power-up");

	AST_ADDR_HOLD: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && $past(por_f) &&
		$past(por_f, 2) |-> $stable(q.addr))
		else $error("address changed while powered");

	AST_APPLY_AT_STOP: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && stop_det && !start_det &&
		q.stg1_v && !clr_f |=> q.reg1 == $past(q.stg1))
		else $error("staged write not applied at stop");

	AST_CLEAR: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) clr_f || !por_f |=>
		q.reg1 == 8'h00 && q.reg2 == 8'h00)
		else $error("registers not cleared");

	AST_BAD_PTR: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) por_f && scl_fall && q.state ==
		rgi_pkg::RGI_ST_PTR && q.bitcnt == 4'h8 && !ptr_ok |=>
		sda_oe_n_o && $stable(q.pointer) && !q.stg1_v)
		else $error("invalid pointer accepted");

	AST_DRIVE_SCL_LOW: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) $changed(q.drive) && $past(por_f) &&
		!$past(start_det) && !$past(stop_det) |-> !$past(scl_f))
		else $error("data line changed with clock high");

	AST_SCL_RELEASED: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i) 1'b1 |-> scl_oe_n_o)
		else $error("clock line driven");

endmodule // rgi_slave

/* tb/rgi_master.sv */
module rgi_master (
	input wire logic clk_i, // bench clock
	input wire logic sda_i, // data wire level
	output logic scl_o, // clock drive, 1 releases
	output logic sda_o // data drive, 1 releases
);
	timeunit 1ns;
	timeprecision 1ns;

	// 12 clocks per level: the slave sees the wire 4 clocks late
	localparam int Q = 6;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one pulse per bit, data moved mid-low only
	task automatic bit_io(input logic b, output logic r);
		hold(Q);
		sda_o <= b;
		hold(Q);
		scl_o <= 1'b1;
		hold(Q);
		r = sda_i;
		hold(Q);
		scl_o <= 1'b0;
	endtask

	task automatic start();
		hold(2 * Q);
		sda_o <= 1'b0;
		hold(Q);
		scl_o <= 1'b0;
	endtask

	// clock left standing high after the frame
	task automatic stop();
		hold(Q);
		sda_o <= 1'b0;
		hold(Q);
		scl_o <= 1'b1;
		hold(Q);
		sda_o <= 1'b1;
		hold(2 * Q);
	endtask

	task automatic put(input logic [7:0] b, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ak = !r;
	endtask

	task automatic get(input logic ak, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(!ak, r);
	endtask
endmodule // rgi_master

/* tb/regulator_i2c_slave_regs_tb.sv */
module regulator_i2c_slave_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0] p;
		logic [1:0] n;
		logic [23:0] d;
		logic [7:0] ak;
		logic [7:0] r0;
		logic [7:0] r1;
	} rgi_row_t;

	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic por_ok = 1'b1;
	logic strap_hi = 1'b0;
	logic strap_rst = 1'b0;
	logic ph2 = 1'b0;
	logic m_scl, m_sda, scl_oe_n, sda_oe_n, scl_d, sda_d;
	logic two_ph, bus_act, ovp, dts;
	logic [7:0] reg0, reg1;
	logic [5:0] ofs;
	logic [2:0] frq;
	wire logic scl_w = m_scl & (scl_oe_n | scl_d);
	wire logic sda_w = m_sda & (sda_oe_n | sda_d);
	int err_count = 0;
	int compares = 0;
	rgi_row_t rows [6] = '{
		'{8'h00, 2'h1, 24'h3F0000, 8'h07, 8'h3F, 8'h00},
		'{8'h01, 2'h1, 24'hA50000, 8'h07, 8'h3F, 8'hA5},
		'{8'h00, 2'h2, 24'h155A00, 8'h0F, 8'h15, 8'h5A},
		'{8'h00, 2'h3, 24'hC33C7E, 8'h1F, 8'hC3, 8'h3C},
		'{8'h02, 2'h1, 24'h770000, 8'h01, 8'hC3, 8'h3C},
		'{8'h01, 2'h2, 24'h912200, 8'h0F, 8'hC3, 8'h91}
	};

	always #10 ref_clk_i = ~ref_clk_i;

	rgi_slave u_rgi_slave (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.por_ok_i(por_ok),
		.softstart_address_strap_pin_hi_i(strap_hi),
		.softstart_address_strap_pin_rst_i(strap_rst),
		.second_phase_enable_pin_i(ph2),
		.scl_i(scl_w),
		.scl_o(scl_d),
		.scl_oe_n_o(scl_oe_n),
		.sda_i(sda_w),
		.sda_o(sda_d),
		.sda_oe_n_o(sda_oe_n),
		.margin_offset_register_o(reg0),
		.deadtime_ovp_frequency_register_o(reg1),
		.offset_steps_o(ofs),
		.freq_adjust_o(frq),
		.ovp_alternate_o(ovp),
		.deadtime_scheme_o(dts),
		.two_phase_o(two_ph),
		.bus_active_o(bus_act)
	);

	rgi_master u_rgi_master (
		.clk_i(ref_clk_i),
		.sda_i(sda_w),
		.scl_o(m_scl),
		.sda_o(m_sda)
	);

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_regs(input logic [7:0] e0, input logic [7:0] e1);
		cmp(reg0, e0);
		cmp({2'h0, ofs}, {2'h0, e0[5:0]});
		cmp(reg1, e1);
		cmp({3'h0, dts, ovp, frq}, {3'h0, e1[4:0]});
		cmp({7'h00, two_ph}, {7'h00, ph2 | ~e1[7]});
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
		input logic [23:0] d, output logic [7:0] ak);
		logic k;
		ak = 8'h00;
		u_rgi_master.start();
		u_rgi_master.put({a, 1'b0}, k);
		ak[0] = k;
		u_rgi_master.put(p, k);
		ak[1] = k;
		for (int i = 0; i < n; i++) begin
			u_rgi_master.put(d[23 - 8 * i -: 8], k);
			ak[i + 2] = k;
		end
		u_rgi_master.stop();
	endtask

	task automatic rd(input logic [6:0] a, input int n, output logic ak,
		output logic [7:0] q0, output logic [7:0] q1);
		u_rgi_master.start();
		u_rgi_master.put({a, 1'b1}, ak);
		u_rgi_master.get(n > 1, q0);
		q1 = 8'hFF;
		if (n > 1) u_rgi_master.get(1'b0, q1);
		u_rgi_master.stop();
	endtask

	task automatic conclude();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] ak, q0, q1;
		logic k;
		repeat (6) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		chk_regs(8'h00, 8'h00);
		cmp({4'h0, scl_d, sda_d, sda_oe_n, scl_oe_n}, 8'h0B);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(7'h46, rows[i].p, rows[i].n, rows[i].d, ak);
			cmp(ak, rows[i].ak);
			chk_regs(rows[i].r0, rows[i].r1);
			$display("row %0d done", i);
		end
		wr(7'h46, 8'h00, 0, 24'h000000, ak);
		rd(7'h46, 2, k, q0, q1);
		cmp({7'h00, k}, 8'h01);
		cmp(q0, 8'hC3);
		cmp(q1, 8'h91);
		wr(7'h46, 8'h01, 0, 24'h000000, ak);
		rd(7'h46, 2, k, q0, q1);
		cmp(q0, 8'h91);
		cmp(q1, 8'hFF);
		$display("read test done");
		wr(7'h47, 8'h00, 1, 24'h550000, ak);
		cmp(ak, 8'h00);
		ph2 <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		chk_regs(8'hC3, 8'h91);
		ph2 <= 1'b0;
		strap_rst <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		strap_rst <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		chk_regs(8'h00, 8'h00);
		$display("pin test done");
		wr(7'h46, 8'h00, 1, 24'h2A0000, ak);
		por_ok <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		cmp({7'h00, bus_act}, 8'h00);
		chk_regs(8'h00, 8'h00);
		wr(7'h46, 8'h00, 1, 24'h2A0000, ak);
		cmp(ak, 8'h00);
		strap_hi <= 1'b1;
		por_ok <= 1'b1;
		repeat (12) @(posedge ref_clk_i);
		strap_hi <= 1'b0;
		wr(7'h46, 8'h00, 1, 24'h2A0000, ak);
		cmp(ak, 8'h00);
		wr(7'h47, 8'h00, 1, 24'h2A0000, ak);
		cmp(ak, 8'h07);
		chk_regs(8'h2A, 8'h00);
		cmp({7'h00, bus_act}, 8'h01);
		$display("supply test done");
		// mid-run reset with the strap low: address must be latched afresh
		arst_n_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		chk_regs(8'h00, 8'h00);
		wr(7'h46, 8'h01, 1, 24'h800000, ak);
		cmp(ak, 8'h07);
		chk_regs(8'h00, 8'h80);
		$display("async reset test done");
		conclude();
	end

	// about 11.6k clocks expected; cut off well beyond
	initial begin
		#1_500_000;
		err_count++;
		conclude();
	end
endmodule // regulator_i2c_slave_regs_tb
